// ==== rtl/trl_pkg.sv ====
// Contract
// - ringing select clear: 9-bit frequency code is output frequency divided by ten.
// - frequency code bit 8 in first register bit 0, bits 7..0 in the next register.
// - ringing select set: upper three code bits ignored, low six bits used.
// - ringing code equals frequency in hertz, 15 to 50 Hz in 1 Hz steps.
// - ringing config bit 3 picks voice-band or ringing for channel 1 generator 1.
// - ringing config bit 7 picks voice-band or ringing for channel 2 generator 1.
// - channel 1 frequency and level always come from the same register pair.
// - channel 2 frequency and level come from its own separate register pair.
// - channel 2 waveform field bits 6..4 act only while channel 2 ringing set.
// - channel 1 waveform field bits 2..0 act only while channel 1 ringing set.
// - waveform code 0 is sinusoid; 1..7 trapezoid crest 1.225 plus 0.025 per step.
// - channel 2 level register bits 7..4 set receive attenuation.
// - channel 2 level register bits 3..0 set transmit attenuation.
// - level code n below 15 attenuates n dB; code 15 mutes the path.
// - 7-bit channel 1 level field is ten times level plus 12.2; zero is off.
package trl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  localparam logic [ADDR_W-1:0] OFS_LEVEL_MSB  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FREQ_LOW   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RING_CFG   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CH2_LEVELS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h10;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  localparam int unsigned FREQ_MSB_BIT  = 0;
  localparam int unsigned LEVEL_LSB     = 1;
  localparam int unsigned LEVEL_MSB     = 7;
  localparam int unsigned CH1_RING_BIT  = 3;
  localparam int unsigned CH2_RING_BIT  = 7;
  localparam int unsigned CH1_WAVE_LSB  = 0;
  localparam int unsigned CH1_WAVE_MSB  = 2;
  localparam int unsigned CH2_WAVE_LSB  = 4;
  localparam int unsigned CH2_WAVE_MSB  = 6;
  localparam int unsigned RX_LSB        = 4;
  localparam int unsigned RX_MSB        = 7;
  localparam int unsigned TX_LSB        = 0;
  localparam int unsigned TX_MSB        = 3;

  localparam int unsigned FREQ_W   = 9;
  localparam int unsigned RING_W   = 6;
  localparam int unsigned HZ_W     = 12;
  localparam int unsigned WAVE_W   = 3;
  localparam int unsigned CREST_W  = 11;
  localparam int unsigned ATTEN_W  = 4;
  localparam int unsigned LEVEL_W  = 7;

  localparam logic [3:0]         VOICE_STEP_HZ  = 4'ha;
  localparam logic [FREQ_W-1:0]  VOICE_MIN_CODE = 9'h01e;
  localparam logic [FREQ_W-1:0]  VOICE_MAX_CODE = 9'h154;
  localparam logic [RING_W-1:0]  RING_MIN_HZ    = 6'h0f;
  localparam logic [RING_W-1:0]  RING_MAX_HZ    = 6'h32;
  localparam logic [CREST_W-1:0] CREST_BASE_MILLI = 11'h4c9;
  localparam logic [CREST_W-1:0] CREST_STEP_MILLI = 11'h019;
  localparam logic [WAVE_W-1:0]  WAVE_SINE      = 3'h0;
  localparam logic [ATTEN_W-1:0] ATTEN_MUTE     = 4'hf;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF      = 7'h00;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } trl_apb_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } trl_apb_rsp_type;

  typedef struct packed {
    logic               ring;
    logic [FREQ_W-1:0]  freq_code;
    logic [HZ_W-1:0]    freq_hz;
    logic               in_band;
    logic [WAVE_W-1:0]  wave;
    logic               trapezoid;
    logic [CREST_W-1:0] crest_milli;
  } trl_tone_type;

  typedef struct packed {
    logic [ATTEN_W-1:0] atten_db;
    logic               mute;
  } trl_path_type;

  typedef struct packed {
    logic [REG_W-1:0]   level_msb_q;
    logic [REG_W-1:0]   freq_low_q;
    logic [REG_W-1:0]   ring_cfg_q;
    logic [REG_W-1:0]   ch2_levels_q;
    logic [DATA_W-1:0]  rdata_q;
    trl_tone_type       ch1_q;
    trl_tone_type       ch2_q;
    trl_path_type       rx_q;
    trl_path_type       tx_q;
    logic [LEVEL_W-1:0] ch1_level_q;
    logic               ch1_on_q;
  } trl_state_type;

endpackage : trl_pkg

// ==== rtl/trl_tone_decode.sv ====
`timescale 1ns/100ps
module trl_tone_decode
  import trl_pkg::*;
(
  input  wire logic                        ring_sel_in,
  input  wire logic [trl_pkg::FREQ_W-1:0]  freq_code_in,
  input  wire logic [trl_pkg::WAVE_W-1:0]  wave_in,
  output trl_pkg::trl_tone_type            tone_out
);
  logic [trl_pkg::HZ_W-1:0]    voice_hz;
  logic [trl_pkg::WAVE_W-1:0]  wave_eff;
  logic [trl_pkg::RING_W-1:0]  ring_code;

  always_comb begin
    ring_code = freq_code_in[RING_W-1:0];
    // widen before the product so 340 * 10 does not wrap at nine bits
    voice_hz  = HZ_W'(freq_code_in) * HZ_W'(VOICE_STEP_HZ);
    wave_eff  = ring_sel_in ? wave_in : WAVE_SINE;
    tone_out.ring = ring_sel_in;
    if (ring_sel_in) begin
      // upper bits dropped so downstream never sees stale voice code
      tone_out.freq_code = FREQ_W'(ring_code);
      tone_out.freq_hz   = HZ_W'(ring_code);
      tone_out.in_band   = (ring_code >= RING_MIN_HZ) && (ring_code <= RING_MAX_HZ);
    end else begin
      tone_out.freq_code = freq_code_in;
      tone_out.freq_hz   = voice_hz;
      tone_out.in_band   = (freq_code_in >= VOICE_MIN_CODE) && (freq_code_in <= VOICE_MAX_CODE);
    end
    tone_out.wave      = wave_eff;
    tone_out.trapezoid = (wave_eff != WAVE_SINE);
    if (wave_eff == WAVE_SINE) begin
      tone_out.crest_milli = '0;
    end else begin
      tone_out.crest_milli = CREST_W'(CREST_BASE_MILLI
                           + CREST_STEP_MILLI * (CREST_W'(wave_eff) - CREST_W'(1)));
    end
  end
endmodule : trl_tone_decode

// ==== rtl/trl_level_decode.sv ====
`timescale 1ns/100ps
module trl_level_decode
  import trl_pkg::*;
(
  input  wire logic [trl_pkg::ATTEN_W-1:0] code_in,
  output trl_pkg::trl_path_type            path_out
);
  always_comb begin
    path_out.mute     = (code_in == ATTEN_MUTE);
    path_out.atten_db = (code_in == ATTEN_MUTE) ? '0 : code_in;
  end
endmodule : trl_level_decode

// ==== rtl/trl_top.sv ====
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module trl_top
  import trl_pkg::*;
(
  input  wire logic                         CORE_CLK_IN,
  input  wire logic                         RESET_N_IN,
  input  wire logic                         CLK_EN_IN,
  input  trl_pkg::trl_apb_req_type          APB_REQ_IN,
  output trl_pkg::trl_apb_rsp_type          APB_RSP_OUT,
  input  wire logic [trl_pkg::FREQ_W-1:0]   CH2_FREQ_CODE_IN,
  output trl_pkg::trl_tone_type             CH1_TONE_OUT,
  output trl_pkg::trl_tone_type             CH2_TONE_OUT,
  output trl_pkg::trl_path_type             CH2_RX_OUT,
  output trl_pkg::trl_path_type             CH2_TX_OUT,
  output logic [trl_pkg::LEVEL_W-1:0]       CH1_LEVEL_CODE_OUT,
  output logic                              CH1_TONE_ON_OUT
);
  import trl_pkg::*;

  trl_state_type s_q;
  trl_state_type s_d;
  trl_tone_type  ch1_dec;
  trl_tone_type  ch2_dec;
  trl_path_type  rx_dec;
  trl_path_type  tx_dec;
  logic          setup_ph;
  logic          access_ph;
  logic          addr_hit;
  logic          wr_en;
  logic [FREQ_W-1:0]  ch1_code;
  logic [DATA_W-1:0]  rd_mux;
  logic [DATA_W-1:0]  status_word;

  if (FREQ_W != RING_W + 3) begin : g_width_chk
    $error("frequency code must be six ringing bits plus three");
  end

  // registers hold bus-visible fields, the channel 1 code spans two of them
  assign ch1_code = {s_q.level_msb_q[FREQ_MSB_BIT], s_q.freq_low_q};

  trl_tone_decode u_ch1_tone (
    .ring_sel_in  (s_q.ring_cfg_q[CH1_RING_BIT]),
    .freq_code_in (ch1_code),
    .wave_in      (s_q.ring_cfg_q[CH1_WAVE_MSB:CH1_WAVE_LSB]),
    .tone_out     (ch1_dec)
  );

  // channel 2 code lives in its own register pair outside this block
  trl_tone_decode u_ch2_tone (
    .ring_sel_in  (s_q.ring_cfg_q[CH2_RING_BIT]),
    .freq_code_in (CH2_FREQ_CODE_IN),
    .wave_in      (s_q.ring_cfg_q[CH2_WAVE_MSB:CH2_WAVE_LSB]),
    .tone_out     (ch2_dec)
  );

  trl_level_decode u_rx_level (
    .code_in  (s_q.ch2_levels_q[RX_MSB:RX_LSB]),
    .path_out (rx_dec)
  );

  trl_level_decode u_tx_level (
    .code_in  (s_q.ch2_levels_q[TX_MSB:TX_LSB]),
    .path_out (tx_dec)
  );

  assign setup_ph  = APB_REQ_IN.psel && !APB_REQ_IN.penable;
  assign access_ph = APB_REQ_IN.psel && APB_REQ_IN.penable;
  assign addr_hit  = (APB_REQ_IN.paddr == OFS_LEVEL_MSB)
                  || (APB_REQ_IN.paddr == OFS_FREQ_LOW)
                  || (APB_REQ_IN.paddr == OFS_RING_CFG)
                  || (APB_REQ_IN.paddr == OFS_CH2_LEVELS)
                  || (APB_REQ_IN.paddr == OFS_STATUS);
  // a frozen clock enable stalls the access, so no write is lost
  assign wr_en     = access_ph && CLK_EN_IN && APB_REQ_IN.pwrite && addr_hit;

  assign status_word = {{(DATA_W-8){1'b0}},
                        s_q.tx_q.mute, s_q.rx_q.mute,
                        s_q.ch2_q.in_band, s_q.ch2_q.ring,
                        s_q.ch1_q.trapezoid, s_q.ch1_q.in_band,
                        s_q.ch1_q.ring, s_q.ch1_on_q};

  always_comb begin
    unique case (APB_REQ_IN.paddr)
      OFS_LEVEL_MSB:  rd_mux = DATA_W'(s_q.level_msb_q);
      OFS_FREQ_LOW:   rd_mux = DATA_W'(s_q.freq_low_q);
      OFS_RING_CFG:   rd_mux = DATA_W'(s_q.ring_cfg_q);
      OFS_CH2_LEVELS: rd_mux = DATA_W'(s_q.ch2_levels_q);
      OFS_STATUS:     rd_mux = status_word;
      default:        rd_mux = '0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    if (setup_ph && !APB_REQ_IN.pwrite) begin
      s_d.rdata_q = rd_mux;
    end
    if (wr_en) begin
      unique case (APB_REQ_IN.paddr)
        OFS_LEVEL_MSB:  s_d.level_msb_q  = APB_REQ_IN.pwdata[REG_W-1:0];
        OFS_FREQ_LOW:   s_d.freq_low_q   = APB_REQ_IN.pwdata[REG_W-1:0];
        OFS_RING_CFG:   s_d.ring_cfg_q   = APB_REQ_IN.pwdata[REG_W-1:0];
        OFS_CH2_LEVELS: s_d.ch2_levels_q = APB_REQ_IN.pwdata[REG_W-1:0];
        default:        s_d.rdata_q      = s_q.rdata_q; // status is read-only
      endcase
    end
    // decoded outputs trail register writes by one cycle
    s_d.ch1_q       = ch1_dec;
    s_d.ch2_q       = ch2_dec;
    s_d.rx_q        = rx_dec;
    s_d.tx_q        = tx_dec;
    s_d.ch1_level_q = s_q.level_msb_q[LEVEL_MSB:LEVEL_LSB];
    s_d.ch1_on_q    = (s_q.level_msb_q[LEVEL_MSB:LEVEL_LSB] != LEVEL_OFF);
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s_q <= '0;
    end else if (CLK_EN_IN) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    APB_RSP_OUT.pready  = CLK_EN_IN;
    APB_RSP_OUT.pslverr = access_ph && !addr_hit;
    APB_RSP_OUT.prdata  = s_q.rdata_q;
  end

  assign CH1_TONE_OUT       = s_q.ch1_q;
  assign CH2_TONE_OUT       = s_q.ch2_q;
  assign CH2_RX_OUT         = s_q.rx_q;
  assign CH2_TX_OUT         = s_q.tx_q;
  assign CH1_LEVEL_CODE_OUT = s_q.ch1_level_q;
  assign CH1_TONE_ON_OUT    = s_q.ch1_on_q;

  // checks, all but a_crest, a_reset_zero and the covers gated on the clock enable letting state move
  property p_freq_write;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (wr_en && APB_REQ_IN.paddr == OFS_FREQ_LOW)
      |=> (s_q.freq_low_q == $past(APB_REQ_IN.pwdata[REG_W-1:0]));
  endproperty
  a_freq_write: assert property (p_freq_write) else $error("freq low write lost");

  property p_voice_hz;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (CLK_EN_IN && !s_q.ring_cfg_q[CH1_RING_BIT])
      |=> (CH1_TONE_OUT.freq_hz == HZ_W'($past(ch1_code)) * HZ_W'(VOICE_STEP_HZ));
  endproperty
  a_voice_hz: assert property (p_voice_hz) else $error("voice frequency not code times ten");

  property p_ring_upper;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (CLK_EN_IN && s_q.ring_cfg_q[CH1_RING_BIT])
      |=> (CH1_TONE_OUT.freq_code[FREQ_W-1:RING_W] == '0) && CH1_TONE_OUT.ring;
  endproperty
  a_ring_upper: assert property (p_ring_upper) else $error("ringing upper bits not ignored");

  property p_ring_hz;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (CLK_EN_IN && s_q.ring_cfg_q[CH1_RING_BIT])
      |=> (CH1_TONE_OUT.freq_hz == HZ_W'($past(s_q.freq_low_q[RING_W-1:0])));
  endproperty
  a_ring_hz: assert property (p_ring_hz) else $error("ringing frequency not code in hertz");

  property p_ch2_wave_gate;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (CLK_EN_IN && !s_q.ring_cfg_q[CH2_RING_BIT]) |=> (CH2_TONE_OUT.wave == WAVE_SINE);
  endproperty
  a_ch2_wave_gate: assert property (p_ch2_wave_gate) else $error("ch2 waveform leaks");

  property p_ch1_wave_gate;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (CLK_EN_IN && s_q.ring_cfg_q[CH1_RING_BIT])
      |=> (CH1_TONE_OUT.wave == $past(s_q.ring_cfg_q[CH1_WAVE_MSB:CH1_WAVE_LSB]));
  endproperty
  a_ch1_wave_gate: assert property (p_ch1_wave_gate) else $error("ch1 waveform not used");

  property p_crest;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      CH1_TONE_OUT.trapezoid |-> (CH1_TONE_OUT.crest_milli == CREST_W'(CREST_BASE_MILLI
        + CREST_STEP_MILLI * (CREST_W'(CH1_TONE_OUT.wave) - CREST_W'(1))));
  endproperty
  a_crest: assert property (p_crest) else $error("crest factor wrong");

  property p_rx_level;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      CLK_EN_IN |=> ($past(s_q.ch2_levels_q[RX_MSB:RX_LSB]) == ATTEN_MUTE)
        ? CH2_RX_OUT.mute
        : (CH2_RX_OUT.atten_db == $past(s_q.ch2_levels_q[RX_MSB:RX_LSB]));
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("rx attenuation wrong");

  property p_tx_mute;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      CLK_EN_IN |=> (CH2_TX_OUT.mute == ($past(s_q.ch2_levels_q[TX_MSB:TX_LSB]) == ATTEN_MUTE));
  endproperty
  a_tx_mute: assert property (p_tx_mute) else $error("tx mute wrong");

  property p_level_off;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      CLK_EN_IN |=> (CH1_TONE_ON_OUT == ($past(s_q.level_msb_q[LEVEL_MSB:LEVEL_LSB]) != LEVEL_OFF));
  endproperty
  a_level_off: assert property (p_level_off) else $error("level zero not off");

  property p_ch1_select;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      CLK_EN_IN |=> (CH1_TONE_OUT.ring == $past(s_q.ring_cfg_q[CH1_RING_BIT]));
  endproperty
  a_ch1_select: assert property (p_ch1_select) else $error("ch1 mode select lost");

  property p_ch2_select;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      CLK_EN_IN |=> (CH2_TONE_OUT.ring == $past(s_q.ring_cfg_q[CH2_RING_BIT]));
  endproperty
  a_ch2_select: assert property (p_ch2_select) else $error("ch2 mode select lost");

  property p_ch2_code;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (CLK_EN_IN && !s_q.ring_cfg_q[CH2_RING_BIT])
      |=> (CH2_TONE_OUT.freq_code == $past(CH2_FREQ_CODE_IN));
  endproperty
  a_ch2_code: assert property (p_ch2_code) else $error("ch2 code not from own pair");

  property p_tx_level;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (CLK_EN_IN && (s_q.ch2_levels_q[TX_MSB:TX_LSB] != ATTEN_MUTE))
      |=> (CH2_TX_OUT.atten_db == $past(s_q.ch2_levels_q[TX_MSB:TX_LSB]));
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("tx attenuation wrong");

  property p_level_code;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      CLK_EN_IN |=> (CH1_LEVEL_CODE_OUT == $past(s_q.level_msb_q[LEVEL_MSB:LEVEL_LSB]));
  endproperty
  a_level_code: assert property (p_level_code) else $error("ch1 level code lost");

  property p_reset_zero;
    @(posedge CORE_CLK_IN)
      $rose(RESET_N_IN) |-> (s_q.ring_cfg_q == REG_RESET) && (s_q.ch2_levels_q == REG_RESET)
        && (s_q.level_msb_q == REG_RESET) && !CH1_TONE_OUT.ring;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset");

  property p_cov_ring;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) CH1_TONE_OUT.ring && CH1_TONE_OUT.in_band;
  endproperty
  c_ring: cover property (p_cov_ring);

  property p_cov_trap;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) CH2_TONE_OUT.trapezoid;
  endproperty
  c_trap: cover property (p_cov_trap);

  property p_cov_mute;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) CH2_RX_OUT.mute && CH2_TX_OUT.mute;
  endproperty
  c_mute: cover property (p_cov_mute);

  property p_cov_err;
    @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN) APB_RSP_OUT.pslverr && APB_RSP_OUT.pready;
  endproperty
  c_err: cover property (p_cov_err);

endmodule : trl_top

// ==== testbench/trl_testbench.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import trl_pkg::*;
  logic            clk;
  logic            rst_n;
  logic            clk_en;
  trl_apb_req_type req;
  trl_apb_rsp_type rsp;
  logic [8:0]      ch2_code;
  trl_tone_type    ch1_tone;
  trl_tone_type    ch2_tone;
  trl_path_type    rx;
  trl_path_type    tx;
  logic [6:0]      lvl_code;
  logic            tone_on;
  int              error_cnt;
  int              check_count;
  logic [31:0]     seed;
  logic [7:0]      m_reg [4];
  logic [31:0]     rd;
  logic [31:0]     rnd;
  logic            er;
  logic [8:0]      f;
  int              codes [8] = '{30, 340, 29, 341, 15, 50, 14, 51};

  trl_top dut_u (
    .CORE_CLK_IN        (clk),
    .RESET_N_IN         (rst_n),
    .CLK_EN_IN          (clk_en),
    .APB_REQ_IN         (req),
    .APB_RSP_OUT        (rsp),
    .CH2_FREQ_CODE_IN   (ch2_code),
    .CH1_TONE_OUT       (ch1_tone),
    .CH2_TONE_OUT       (ch2_tone),
    .CH2_RX_OUT         (rx),
    .CH2_TX_OUT         (tx),
    .CH1_LEVEL_CODE_OUT (lvl_code),
    .CH1_TONE_ON_OUT    (tone_on)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic trl_tone_type exp_tone(logic r, logic [8:0] c, logic [2:0] w);
    trl_tone_type t;
    int           hz;
    hz            = r ? int'(c[5:0]) : int'(c) * 10;
    t.ring        = r;
    t.freq_code   = r ? {3'h0, c[5:0]} : c;
    t.freq_hz     = 12'(hz);
    t.in_band     = r ? (hz >= 15 && hz <= 50) : (hz >= 300 && hz <= 3400);
    t.wave        = r ? w : 3'h0;
    t.trapezoid   = (t.wave != 3'h0);
    t.crest_milli = t.trapezoid ? 11'(1225 + 25 * (int'(t.wave) - 1)) : 11'h000;
    return t;
  endfunction : exp_tone

  function automatic trl_path_type exp_path(logic [3:0] n);
    trl_path_type p;
    p.mute     = (n == 4'hf);
    p.atten_db = p.mute ? 4'h0 : n;
    return p;
  endfunction : exp_path

  // caller sits just after a rising edge; one idle edge keeps drives apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("mismatch pready expected 1 seen %0h", rsp.pready);
      conclude();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic check_all();
    trl_tone_type t1;
    trl_tone_type t2;
    trl_path_type pr;
    trl_path_type pt;
    t1 = exp_tone(m_reg[2][3], {m_reg[0][0], m_reg[1]}, m_reg[2][2:0]);
    t2 = exp_tone(m_reg[2][7], ch2_code, m_reg[2][6:4]);
    pr = exp_path(m_reg[3][7:4]);
    pt = exp_path(m_reg[3][3:0]);
    repeat (2) @(posedge clk);
    `CHK("ch1_tone", t1, ch1_tone)
    `CHK("ch2_tone", t2, ch2_tone)
    `CHK("rx_path", pr, rx)
    `CHK("tx_path", pt, tx)
    `CHK("level_code", m_reg[0][7:1], lvl_code)
    `CHK("tone_on", (m_reg[0][7:1] != 7'h00), tone_on)
    apb(1'b0, OFS_STATUS, 32'h0, rd, er);
    `CHK("status", {24'h0, pt.mute, pr.mute, t2.in_band, t2.ring, t1.trapezoid,
                    t1.in_band, t1.ring, (m_reg[0][7:1] != 7'h00)}, rd)
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, rd, er);
      `CHK("reg_readback", {24'h0, m_reg[i]}, rd)
    end
  endtask : check_all

  task automatic apply(input logic [7:0] l, input logic [7:0] fr, input logic [7:0] c,
                       input logic [7:0] v);
    m_reg = '{l, fr, c, v};
    for (int i = 0; i < 4; i++) begin
      rnd = xs();
      apb(1'b1, 8'(i * 4), {rnd[23:0], m_reg[i]}, rd, er);
      `CHK("write_err", 1'b0, er)
    end
    check_all();
  endtask : apply

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial begin
    clk_en   = 1'b1;
    req      = '0;
    ch2_code = '0;
    rst_n    = 1'b0;
    seed     = 32'h7bece253;
    m_reg    = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_all();
    $display("test reset values done");
    // ch1 and ch2 ringing selects opposite, so every shape meets both modes
    for (int w = 0; w < 16; w++) begin
      apply(8'h02, 8'hd4, {w[3], w[2:0], ~w[3], w[2:0]}, 8'h00);
    end
    $display("test waveform codes done");
    for (int n = 0; n < 16; n++) begin
      apply(8'h00, 8'h00, 8'h00, {n[3:0], ~n[3:0]});
    end
    $display("test level codes done");
    for (int k = 0; k < 8; k++) begin
      f = (k < 4) ? 9'(codes[k]) : 9'(codes[k]) | 9'h1c0;
      apply({7'h40, f[8]}, f[7:0], {4'h0, (k >= 4), 3'h1}, 8'h00);
    end
    $display("test frequency bounds done");
    for (int k = 0; k < 24; k++) begin
      ch2_code <= 9'(xs() % 400);
      f = 9'(xs() % 400);
      rnd = xs();
      apply({rnd[6:0], f[8]}, f[7:0], rnd[15:8], rnd[23:16]);
    end
    $display("test random settings done");
    apb(1'b1, 8'h14, 32'hff, rd, er);
    `CHK("unmapped_write_err", 1'b1, er)
    apb(1'b0, 8'h14, 32'h0, rd, er);
    `CHK("unmapped_read_err", 1'b1, er)
    `CHK("unmapped_read_data", 32'h0, rd)
    apb(1'b1, OFS_STATUS, 32'hff, rd, er);
    check_all();
    $display("test refused access done");
    clk_en <= 1'b0;
    fork
      apb(1'b1, OFS_RING_CFG, 32'h88, rd, er);
      begin
        repeat (3) @(posedge clk);
        `CHK("stalled_pready", 1'b0, rsp.pready)
        clk_en <= 1'b1;
      end
    join
    m_reg[2] = 8'h88;
    check_all();
    $display("test clock enable stall done");
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    m_reg = '{8'h00, 8'h00, 8'h00, 8'h00};
    check_all();
    $display("test second reset done");
    conclude();
  end
endmodule : testbench
